// >>> hdl/selector_pkg.sv
// Constants, types and tables for the position selector controller.
// Assumes a 100 MHz mclk and an Avalon-MM slave with byte addresses.
package selector_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ             = 32'h05F5E100;
  localparam int unsigned MS_PER_S           = 32'h000003E8;
  localparam int unsigned CYCLES_PER_MS      = CLK_HZ / MS_PER_S;
  localparam int unsigned HOME_SINGLE_MS     = 32'h000005AA;
  localparam int unsigned HOME_DUAL_MS       = 32'h00001068;
  localparam int unsigned HOME_SINGLE_CYCLES = HOME_SINGLE_MS * CYCLES_PER_MS;
  localparam int unsigned HOME_DUAL_CYCLES   = HOME_DUAL_MS * CYCLES_PER_MS;
  localparam int unsigned DEBOUNCE_MS        = 32'h00000005;
  localparam int unsigned DEBOUNCE_CYCLES    = DEBOUNCE_MS * CYCLES_PER_MS;
  localparam logic [1:0]  SETTLE_CYCLES      = 2'h2;

  // ==========================================================
  // Move times per config index {dual, row}, in ms
  localparam logic [8:0] FIRST_MS [0:7] = '{9'h096, 9'h073, 9'h060, 9'h055,
                                            9'h10D, 9'h0D4, 9'h0B8, 9'h09A};
  localparam logic [8:0] ADDL_MS  [0:7] = '{9'h06F, 9'h047, 9'h037, 9'h02B,
                                            9'h0E6, 9'h0AD, 9'h085, 9'h076};
  localparam logic [3:0] POS_COUNT [0:7] = '{4'h4, 4'h6, 4'h8, 4'hA,
                                             4'h6, 4'h8, 4'hA, 4'hC};
  localparam logic [3:0] HOME_POS      = 4'h1;
  localparam logic [3:0] TWO_POS_COUNT = 4'h2;
  localparam int unsigned NUM_IND      = 12;

  // ==========================================================
  // Register map
  localparam logic [3:0] CTRL_OFS      = 4'h0;
  localparam logic [3:0] STATUS_OFS    = 4'h4;
  localparam int unsigned CTRL_STEP_BIT = 0;
  localparam int unsigned CTRL_HOME_BIT = 1;
  localparam int unsigned STAT_POS_LSB  = 0;
  localparam int unsigned STAT_CNT_LSB  = 8;
  localparam int unsigned STAT_BUSY     = 12;
  localparam int unsigned STAT_HOMED    = 13;
  localparam int unsigned STAT_CCW      = 14;
  localparam int unsigned STAT_DUAL     = 15;
  localparam int unsigned STAT_MULTI    = 16;
  localparam int unsigned STAT_BAUD     = 17;
  localparam int unsigned STAT_STEPC    = 18;
  localparam int unsigned STAT_HOMEC    = 19;

  // ==========================================================
  // Types
  typedef struct packed {
    logic ccw;
    logic port2;
    logic port3;
    logic multi;
    logic baud_restore;
    logic dual;
  } strap_t;

  typedef enum logic [1:0] {
    ST_SAMPLE = 2'b00,
    ST_HOMING = 2'b01,
    ST_IDLE   = 2'b10,
    ST_MOVE   = 2'b11
  } ctl_state_t;

endpackage

// >>> hdl/contact_debounce.sv
// Synchroniser and debouncer for one contact-closure input.
// Assumes the raw pin is low while closed to common.
`timescale 1ns/1ps
module contact_debounce #(
  parameter int unsigned hold_cycles = selector_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic raw_n,
  output logic      closed,
  output logic      close_pulse
);
  import selector_pkg::*;

  typedef struct packed {
    logic        meta;
    logic        sync;
    logic        closed;
    logic        pulse;
    logic [19:0] cnt;
  } deb_t;

  localparam logic [19:0] HOLD_LAST = 20'(hold_cycles - 1);

  deb_t s;
  deb_t next_s;

  // ==========================================================
  // Filter
  always_comb
  begin
    next_s       = s;
    next_s.meta  = raw_n;
    next_s.sync  = s.meta;
    next_s.pulse = 1'b0;
    if ((~s.sync) != s.closed)
    begin
      if (s.cnt >= HOLD_LAST)
      begin
        next_s.closed = ~s.sync;
        next_s.pulse  = ~s.sync;
        next_s.cnt    = 20'h00000;
      end
      else
        next_s.cnt = s.cnt + 20'h00001;
    end
    else
      next_s.cnt = 20'h00000;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      s <= '{meta: 1'b1, sync: 1'b1, closed: 1'b0, pulse: 1'b0, cnt: 20'h00000};
    else
      s <= next_s;
  end

  assign closed      = s.closed;
  assign close_pulse = s.pulse;

endmodule // contact_debounce

// >>> hdl/segment_timer.sv
// Down counter that times one motion segment or the homing run.
// Assumes start is a one-cycle pulse from the same clock.
`timescale 1ns/1ps
module segment_timer (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        start,
  input  wire logic [31:0] load,
  output logic             done
);
  import selector_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic        run;
    logic        done;
  } tmr_t;

  tmr_t s;
  tmr_t next_s;

  // ==========================================================
  // Count
  always_comb
  begin
    next_s      = s;
    next_s.done = 1'b0;
    if (start)
    begin
      next_s.cnt = load;
      next_s.run = 1'b1;
    end
    else if (s.run)
    begin
      if (s.cnt <= 32'h00000001)
      begin
        next_s.run  = 1'b0;
        next_s.done = 1'b1;
      end
      else
        next_s.cnt = s.cnt - 32'h00000001;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      s <= '{cnt: 32'h00000000, run: 1'b0, done: 1'b0};
    else
      s <= next_s;
  end

  assign done = s.done;

endmodule // segment_timer

// >>> hdl/selector_ctl.sv
// Position selector controller: strap sampling, homing, step and home moves.
// Assumes contact and strap pins are asynchronous; Avalon-MM master on mclk.
`timescale 1ns/1ps
// Summary of operation
// - After reset the unit homes for 1.45 s single stage or 4.2 s dual stage.
// - Homing ends at position 1 and no move is taken before it ends.
// - An indicator is high only while the valve rests at its position.
// - A step closure moves exactly one position in the strapped direction.
// - A home closure drives to position 1 in the strapped direction.
// - A closure acts once when idle; one during homing or a move, or a held contact, is ignored.
// - Direction strap absent gives clockwise rising order, fitted gives ccw.
// - Straps are sampled once after reset and later changes are ignored.
// - Single stage straps 2/3 decode to 4, 6, 8 or 10 positions.
// - Dual stage straps 2/3 decode to 6, 8, 10 or 12 positions.
// - The count holds only the ring ports, never the centre port.
// - Without strap 4 the unit works as a two-position unit.
// - Straps 3 and 4 off with restore fitted asks for the default 9600 rate.
// - Move time is the first-position time plus the per-position time for each further position.
module selector_ctl #(
  parameter int unsigned cycles_per_ms      = selector_pkg::CYCLES_PER_MS,
  parameter int unsigned home_single_cycles = selector_pkg::HOME_SINGLE_CYCLES,
  parameter int unsigned home_dual_cycles   = selector_pkg::HOME_DUAL_CYCLES,
  parameter int unsigned debounce_cycles    = selector_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  input  wire logic                 step_contact_n,
  input  wire logic                 home_contact_n,
  input  wire selector_pkg::strap_t straps,
  input  wire logic [3:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  output logic [11:0]               pos_reached,
  output logic [3:0]                position,
  output logic                      motor_run,
  output logic                      motor_ccw,
  output logic                      ready,
  output logic                      baud_default
);
  import selector_pkg::*;

  typedef struct packed {
    ctl_state_t  state;
    logic [1:0]  settle;
    strap_t      strap_meta;
    strap_t      strap_sync;
    strap_t      cfg;
    logic [2:0]  cfg_idx;
    logic [3:0]  count;
    logic [3:0]  pos;
    logic [3:0]  remain;
    logic        homed;
    logic [11:0] indicator;
    logic        motor_run;
    logic        motor_ccw;
    logic        baud_default;
    logic        tmr_start;
    logic [31:0] tmr_load;
    logic        ack;
    logic        waitreq;
    logic [31:0] readdata;
  } ctl_t;

  ctl_t        s;
  ctl_t        next_s;
  logic [1:0]  raw_n;
  logic [1:0]  closed;
  logic [1:0]  edge_pulse;
  logic        tmr_done;
  logic        bus_step;
  logic        bus_home;
  logic        step_go;
  logic        home_go;
  logic [3:0]  home_dist;
  logic [1:0]  row;
  logic [31:0] first_cycles;
  logic [31:0] addl_cycles;
  logic [31:0] status_word;

  // ==========================================================
  // Contact inputs
  assign raw_n = {home_contact_n, step_contact_n};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_contact
      contact_debounce #(
        .hold_cycles (debounce_cycles)
      ) u_deb (
        .mclk        (mclk),
        .arst_n      (arst_n),
        .raw_n       (raw_n[gi]),
        .closed      (closed[gi]),
        .close_pulse (edge_pulse[gi])
      );
    end
  endgenerate

  segment_timer u_tmr (
    .mclk   (mclk),
    .arst_n (arst_n),
    .start  (s.tmr_start),
    .load   (s.tmr_load),
    .done   (tmr_done)
  );

  // ==========================================================
  // Helpers
  function automatic logic [3:0] adv_pos(input logic [3:0] p, input logic ccw,
                                         input logic [3:0] cnt);
    if (ccw)
      adv_pos = (p == HOME_POS) ? cnt : p - 4'h1;
    else
      adv_pos = (p >= cnt) ? HOME_POS : p + 4'h1;
  endfunction

  function automatic logic [11:0] onehot(input logic [3:0] p);
    onehot = 12'h001 << (p - 4'h1);
  endfunction

  always_comb
  begin
    case ({s.strap_sync.port2, s.strap_sync.port3})
      2'b11:   row = 2'h0;
      2'b00:   row = 2'h1;
      2'b10:   row = 2'h2;
      default: row = 2'h3;
    endcase
  end

  assign first_cycles = 32'(FIRST_MS[s.cfg_idx]) * 32'(cycles_per_ms);
  assign addl_cycles  = 32'(ADDL_MS[s.cfg_idx]) * 32'(cycles_per_ms);
  assign home_dist    = (s.pos == HOME_POS) ? 4'h0 :
                        s.cfg.ccw ? s.pos - HOME_POS : s.count + 4'h1 - s.pos;

  assign status_word = {12'h000, closed[1], closed[0], s.baud_default, s.cfg.multi,
                        s.cfg.dual, s.cfg.ccw, s.homed, s.state != ST_IDLE,
                        s.count, 4'h0, s.pos};

  // ==========================================================
  // Bus requests
  assign bus_step = s.ack && avs_write && (avs_address == CTRL_OFS)
                    && avs_byteenable[0] && avs_writedata[CTRL_STEP_BIT];
  assign bus_home = s.ack && avs_write && (avs_address == CTRL_OFS)
                    && avs_byteenable[0] && avs_writedata[CTRL_HOME_BIT];
  assign step_go  = edge_pulse[0] || bus_step;
  assign home_go  = edge_pulse[1] || bus_home;

  // ==========================================================
  // Control
  always_comb
  begin
    next_s            = s;
    next_s.tmr_start  = 1'b0;
    next_s.ack        = 1'b0;
    next_s.waitreq    = 1'b1;
    next_s.strap_meta = straps;
    next_s.strap_sync = s.strap_meta;
    if ((avs_read || avs_write) && !s.ack)
    begin
      next_s.ack      = 1'b1;
      next_s.waitreq  = 1'b0;
      next_s.readdata = (avs_read && avs_address == STATUS_OFS) ? status_word : 32'h0;
    end
    case (s.state)
      ST_SAMPLE:
      begin
        if (s.settle == SETTLE_CYCLES)
        begin
          next_s.cfg     = s.strap_sync;
          next_s.cfg_idx = {s.strap_sync.dual, row};
          next_s.count   = s.strap_sync.multi ?
                           POS_COUNT[{s.strap_sync.dual, row}] : TWO_POS_COUNT;
          next_s.baud_default = !s.strap_sync.port3 && !s.strap_sync.multi
                                && s.strap_sync.baud_restore;
          next_s.tmr_start = 1'b1;
          next_s.tmr_load  = s.strap_sync.dual ? 32'(home_dual_cycles)
                                               : 32'(home_single_cycles);
          next_s.motor_run = 1'b1;
          next_s.motor_ccw = s.strap_sync.ccw;
          next_s.state     = ST_HOMING;
        end
        else
          next_s.settle = s.settle + 2'h1;
      end
      ST_HOMING:
      begin
        if (tmr_done)
        begin
          next_s.pos       = HOME_POS;
          next_s.homed     = 1'b1;
          next_s.motor_run = 1'b0;
          next_s.indicator = onehot(HOME_POS);
          next_s.state     = ST_IDLE;
        end
      end
      ST_IDLE:
      begin
        if ((home_go && home_dist != 4'h0) || (step_go && !home_go))
        begin
          next_s.remain    = home_go ? home_dist : 4'h1;
          next_s.tmr_start = 1'b1;
          next_s.tmr_load  = first_cycles;
          next_s.indicator = 12'h000;
          next_s.motor_run = 1'b1;
          next_s.motor_ccw = s.cfg.ccw;
          next_s.state     = ST_MOVE;
        end
      end
      ST_MOVE:
      begin
        if (tmr_done)
        begin
          next_s.pos = adv_pos(s.pos, s.cfg.ccw, s.count);
          if (s.remain <= 4'h1)
          begin
            next_s.remain    = 4'h0;
            next_s.motor_run = 1'b0;
            next_s.indicator = onehot(adv_pos(s.pos, s.cfg.ccw, s.count));
            next_s.state     = ST_IDLE;
          end
          else
          begin
            next_s.remain    = s.remain - 4'h1;
            next_s.tmr_start = 1'b1;
            next_s.tmr_load  = addl_cycles;
          end
        end
      end
      default:
        next_s.state = ST_SAMPLE;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s        <= '0;
      s.state  <= ST_SAMPLE;
      s.pos    <= HOME_POS;
      s.count  <= TWO_POS_COUNT;
      s.waitreq <= 1'b1;
    end
    else
      s <= next_s;
  end

  // ==========================================================
  // Outputs
  assign avs_readdata    = s.readdata;
  assign avs_waitrequest = s.waitreq;
  assign pos_reached     = s.indicator;
  assign position        = s.pos;
  assign motor_run       = s.motor_run;
  assign motor_ccw       = s.motor_ccw;
  assign ready           = s.homed;
  assign baud_default    = s.baud_default;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  ind_onehot_a: assert property ($onehot0(s.indicator))
    else $error("indicator not one-hot");
  ind_match_a: assert property (s.indicator != 12'h000 |->
      s.state == ST_IDLE && s.indicator == onehot(s.pos))
    else $error("indicator does not match resting position");
  home_gate_a: assert property (!s.homed |-> s.state inside {ST_SAMPLE, ST_HOMING})
    else $error("move before homing ended");
  home_end_a: assert property ($past(s.state) == ST_HOMING && s.state == ST_IDLE |->
      s.pos == HOME_POS && s.indicator == 12'h001)
    else $error("homing did not end at position 1");
  home_time_a: assert property (s.state == ST_SAMPLE && next_s.state == ST_HOMING |=>
      s.tmr_load == (s.cfg.dual ? home_dual_cycles : home_single_cycles))
    else $error("wrong homing duration");
  strap_hold_a: assert property (s.homed |=> $stable(s.cfg) && $stable(s.count))
    else $error("strap setting changed after sampling");
  count_set_a: assert property (s.homed && s.cfg.multi && !s.cfg.dual |->
      s.count inside {4'h4, 4'h6, 4'h8, 4'hA})
    else $error("illegal single stage count");
  dual_set_a: assert property (s.homed && s.cfg.multi && s.cfg.dual |->
      s.count inside {4'h6, 4'h8, 4'hA, 4'hC})
    else $error("illegal dual stage count");
  two_pos_a: assert property (s.homed && !s.cfg.multi |-> s.count == TWO_POS_COUNT)
    else $error("two-position mode not applied");
  baud_flag_a: assert property (s.homed |-> s.baud_default ==
      (!s.cfg.port3 && !s.cfg.multi && s.cfg.baud_restore))
    else $error("baud restore decode wrong");
  dir_match_a: assert property (s.homed && s.motor_run |-> s.motor_ccw == s.cfg.ccw)
    else $error("motor direction differs from strap");
  step_one_a: assert property (s.homed && $changed(s.pos) |->
      s.pos == adv_pos($past(s.pos), s.cfg.ccw, s.count))
    else $error("position moved by other than one");
  first_seg_a: assert property ($past(s.state) == ST_IDLE && s.state == ST_MOVE |->
      s.tmr_start && s.tmr_load == first_cycles ##1 !s.tmr_start)
    else $error("first segment time wrong");
  busy_drop_a: assert property (s.state == ST_MOVE && !tmr_done |=>
      s.remain == $past(s.remain) && s.state == ST_MOVE)
    else $error("closure taken during a move");
  single_act_a: assert property (edge_pulse[0] |=> !edge_pulse[0] [*2])
    else $error("held step contact acted twice");

  homing_done_c: cover property (s.state == ST_HOMING ##1 s.state == ST_IDLE);
  step_move_c: cover property (s.state == ST_IDLE && step_go ##1 s.remain == 4'h1);
  long_home_c: cover property (s.state == ST_MOVE && s.remain > 4'h1 && tmr_done);
  wrap_c: cover property (s.homed && $changed(s.pos) && s.pos == HOME_POS
      && !s.cfg.ccw && s.remain == 4'h0);

endmodule // selector_ctl

// >>> test/contact_host.sv
// Host-side model: two contact closures to common with pull-ups.
// Assumes the bench calls close_contact right after a rising mclk edge.
`timescale 1ns/1ps
module contact_host (
  input  wire logic mclk,
  output logic      step_n,
  output logic      home_n
);
  // ==========================================================
  // Idle: both contacts open, lines pulled high
  initial
  begin
    step_n = 1'b1;
    home_n = 1'b1;
  end

  // ==========================================================
  // One closure: short bounce, steady close, then open again
  task automatic close_contact(input bit home, input int steady);
    for (int k = 0; k < 5; k++)
    begin
      @(posedge mclk);
      if (home) home_n <= k[0];
      else step_n <= k[0];
    end
    repeat (steady) @(posedge mclk);
    if (home) home_n <= 1'b1;
    else step_n <= 1'b1;
  endtask
endmodule // contact_host

// >>> test/multiposition_selector_control_tb.sv
// Self-checking bench for the selector controller.
// Assumes short sim counts and the contact_host model on the contact pins.
`timescale 1ns/1ps
module multiposition_selector_control_tb;
  import selector_pkg::*;
  localparam int unsigned CPM = 10;
  localparam int unsigned H1  = 200;
  localparam int unsigned H2  = 400;
  localparam int unsigned DEB = 4;
  localparam int unsigned LIMIT_NS = 1_000_000;

  logic        mclk, arst_n, step_n, home_n, run_q, ccw_seen;
  strap_t      straps;
  logic [3:0]  avs_address, avs_byteenable, position;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata;
  logic        motor_run, motor_ccw, ready, baud_default;
  logic [11:0] pos_reached;
  int          error_cnt, n_compared, run_cnt;

  selector_ctl #(.cycles_per_ms(CPM), .home_single_cycles(H1), .home_dual_cycles(H2),
    .debounce_cycles(DEB)) uut (.mclk, .arst_n, .step_contact_n(step_n),
    .home_contact_n(home_n), .straps, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .pos_reached,
    .position, .motor_run, .motor_ccw, .ready, .baud_default);
  contact_host host (.mclk, .step_n, .home_n);

  // ==========================================================
  // Clock, run-length monitor, watchdog
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    run_q <= motor_run;
    if (motor_run) ccw_seen <= motor_ccw;
    if (motor_run && !run_q) run_cnt <= 1;
    else if (motor_run) run_cnt <= run_cnt + 1;
  end

  initial
  begin
    #(LIMIT_NS);
    error_cnt++;
    end_of_test();
  end

  // ==========================================================
  // Compare and report
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_time(input int got, input int exp, input int tol);
    n_compared++;
    if (got < exp - tol || got > exp + tol)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==========================================================
  // Expected values
  function automatic int cfg_idx(strap_t s);
    int row;
    case ({s.port2, s.port3})
      2'b11: row = 0;
      2'b00: row = 1;
      2'b10: row = 2;
      default: row = 3;
    endcase
    return (s.dual ? 4 : 0) + row;
  endfunction

  function automatic logic [3:0] pos_cnt(strap_t s);
    if (!s.multi) return 4'h2;
    return 4'(4 + 2 * (cfg_idx(s) % 4) + (s.dual ? 2 : 0));
  endfunction

  function automatic logic [3:0] nxt(logic [3:0] p, logic [3:0] c, logic ccw);
    if (ccw) return (p == 4'h1) ? c : p - 4'h1;
    return (p == c) ? 4'h1 : p + 4'h1;
  endfunction

  function automatic int mv_time(strap_t s, int d);
    return (int'(FIRST_MS[cfg_idx(s)]) + (d - 1) * int'(ADDL_MS[cfg_idx(s)])) * CPM;
  endfunction

  // ==========================================================
  // Avalon-MM access and move wait
  task automatic bus_xfer(input bit wr, input logic [3:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    int n;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    chk_val({31'h0, avs_waitrequest}, 32'h0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wait_move(output int len);
    int n;
    n = 0;
    while (motor_run !== 1'b1 && n < 100)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 100) error_cnt++;
    @(posedge mclk);
    chk_val(pos_reached, 32'h0);
    n = 0;
    while (motor_run !== 1'b0 && n < 40000)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 40000) error_cnt++;
    len = run_cnt;
  endtask

  // ==========================================================
  // One strap setting: power-up, contact step, bus step, home
  task automatic run_cfg(input int i);
    strap_t s;
    logic [31:0] q;
    logic [3:0] c, p;
    int len, d;
    s.dual = i[2];
    s.port2 = i[1];
    s.port3 = i[0];
    s.multi = (i != 8);
    s.ccw = 1'($urandom % 2);
    s.baud_restore = (i == 8) ? 1'b1 : 1'($urandom % 2);
    c = pos_cnt(s);
    @(posedge mclk);
    arst_n <= 1'b0;
    straps <= s;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    wait_move(len);
    chk_time(len, s.dual ? H2 : H1, 4);
    chk_val(position, 32'h1);
    chk_val(pos_reached, 32'h1);
    chk_val(ready, 32'h1);
    chk_val(baud_default, !s.port3 && !s.multi && s.baud_restore);
    straps <= strap_t'(~s);
    bus_xfer(1'b0, 4'h4, 32'h0, q);
    chk_val({q[17], q[14], q[11:8]}, {s.baud_restore && !s.port3 && !s.multi, s.ccw, c});
    p = nxt(4'h1, c, s.ccw);
    fork
      host.close_contact(1'b0, DEB + mv_time(s, 1) + 150);
      begin
        repeat (DEB + 200) @(posedge mclk);
        host.close_contact(1'b1, DEB + 4);
      end
      wait_move(len);
    join
    chk_time(len, mv_time(s, 1), 3);
    chk_val(position, p);
    chk_val(pos_reached, 32'h1 << (p - 1));
    chk_val(ccw_seen, s.ccw);
    repeat (20) @(posedge mclk);
    chk_val(motor_run, 32'h0);
    bus_xfer(1'b1, 4'h0, 32'h1, q);
    wait_move(len);
    p = nxt(p, c, s.ccw);
    chk_val(position, p);
    chk_time(len, mv_time(s, 1), 3);
    bus_xfer(1'b0, 4'h0, 32'h0, q);
    chk_val(q, 32'h0);
    bus_xfer(1'b0, 4'h8, 32'h0, q);
    chk_val(q, 32'h0);
    d = (p == 4'h1) ? 0 : (s.ccw ? p - 1 : c + 1 - p);
    fork
      if (i[0]) bus_xfer(1'b1, 4'h0, 32'h2, q);
      else host.close_contact(1'b1, DEB + 4);
      if (d > 0) wait_move(len);
    join
    if (d > 0) chk_time(len, mv_time(s, d) + 2 * d, 3);
    if (d > 0) chk_val(ccw_seen, s.ccw);
    repeat (20) @(posedge mclk);
    chk_val(position, 32'h1);
    chk_val(pos_reached, 32'h1);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    arst_n = 1'b0;
    straps = '0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    run_q = 1'b0;
    run_cnt = 0;
    ccw_seen = 1'b0;
    error_cnt = 0;
    n_compared = 0;
    void'($urandom(1));
    for (int i = 0; i < 9; i++) run_cfg(i);
    end_of_test();
  end
endmodule // multiposition_selector_control_tb
